// ---- verilog/dht_defs.svh ----
// offsets, field positions, reset values for the dual half timer
// assumes a 32-bit word bus, one aligned word per register
`ifndef DHT_DEFS_SVH
`define DHT_DEFS_SVH

// number of timer blocks, each with two halves
`define DHT_NBLK 3

// byte offsets inside one block; a block spans 32 bytes
`define DHT_OFF_CFG 5'h00
`define DHT_OFF_LOAD_A 5'h04
`define DHT_OFF_LOAD_B 5'h08
`define DHT_OFF_MATCH_A 5'h0C
`define DHT_OFF_MATCH_B 5'h10
`define DHT_OFF_VAL_A 5'h14
`define DHT_OFF_VAL_B 5'h18
`define DHT_OFF_STAT 5'h1C

// configuration register fields
`define DHT_CFG_JOIN 1:0
`define DHT_CFG_MODE_A_LSB 2
`define DHT_CFG_MODE_B_LSB 5
`define DHT_CFG_EN_A 8
`define DHT_CFG_STALL_A 10
`define DHT_CFG_INV_A 12

// load register: prescale byte above the 16-bit reload value
`define DHT_LOAD_PRESC 23:16
`define DHT_LOAD_VAL 15:0

// status bits: half a, half b, joined counter
`define DHT_STAT_J32 2

`define DHT_CFG_RST 16'h0000
`define DHT_LOAD_RST 24'h00_0000
`define DHT_MATCH_RST 16'h0000

`endif

// ---- verilog/dht_pkg.sv ----
// types shared by the dual half timer modules
// assumes dht_defs.svh is on the include path
`include "dht_defs.svh"

package dht_pkg;

  typedef enum logic [2:0] {DHT_ONESHOT, DHT_PERIODIC, DHT_EDGE_CNT, DHT_EDGE_TIME, DHT_PWM} dht_mode_t;

  typedef enum logic [1:0] {DHT_SPLIT, DHT_JOINED, DHT_RTC} dht_join_t;

  typedef struct packed {
    logic [7:0] pcnt;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic done;
    logic flag;
    logic pwm;
  } dht_half_t;

  typedef struct packed {
    logic [`DHT_NBLK-1:0][15:0] cfg;
    logic [`DHT_NBLK-1:0][23:0] load_a;
    logic [`DHT_NBLK-1:0][23:0] load_b;
    logic [`DHT_NBLK-1:0][15:0] match_a;
    logic [`DHT_NBLK-1:0][15:0] match_b;
    logic [`DHT_NBLK-1:0][31:0] cnt32;
    logic [`DHT_NBLK-1:0] done32;
    logic [`DHT_NBLK-1:0][2:0] stat;
    logic wpend;
    logic [7:0] waddr;
    logic rd_pend;
    logic [7:0] raddr;
    logic [31:0] rdata;
    logic hready;
    logic [2*`DHT_NBLK-1:0] ccp_out;
    logic [2*`DHT_NBLK-1:0] ccp_oe;
  } dht_top_t;

endpackage

// ---- verilog/dht_edge.sv ----
// rising edge detector for pin inputs, one-cycle pulse per edge
// assumes inputs already synchronous to mclk
`timescale 1ns/1ps

module dht_edge #(
  parameter int W = 7
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] rise;
  } dht_edge_t;

  dht_edge_t s_q;
  dht_edge_t s_d;

  // compare with last sample
  always_comb begin
    s_d = s_q;
    s_d.prev = din;
    s_d.rise = din & ~s_q.prev;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise = s_q.rise;

endmodule

// ---- verilog/dht_half.sv ----
// one 16-bit timer half: prescaled timer, edge count, edge time, pwm
// assumes edge_p is a one-cycle pulse and config held while enabled
`timescale 1ns/1ps

module dht_half
  import dht_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic en,
  input wire dht_mode_t mode,
  input wire logic stall,
  input wire logic halt,
  input wire logic inv,
  input wire logic edge_p,
  input wire logic [15:0] load,
  input wire logic [7:0] presc,
  input wire logic [15:0] match,
  output logic [15:0] value,
  output logic flag,
  output logic pwm
);

  dht_half_t s_q;
  dht_half_t s_d;
  logic tmode;
  logic pause;

  assign tmode = (mode == DHT_ONESHOT) || (mode == DHT_PERIODIC);
  assign pause = stall && halt && tmode;

  // next state of the half
  always_comb begin
    s_d = s_q;
    s_d.flag = 1'b0;
    if (!en) begin
      s_d.cnt = load;
      s_d.pcnt = presc;
      s_d.done = 1'b0;
      s_d.pwm = inv;
    end else if (!pause) begin
      case (mode)
        DHT_ONESHOT, DHT_PERIODIC: begin
          if (s_q.pcnt != 8'h00) begin
            s_d.pcnt = s_q.pcnt - 8'h01;
          end else begin
            s_d.pcnt = presc;
            if (!s_q.done) begin
              if (s_q.cnt == 16'h0000) begin
                s_d.flag = 1'b1;
                if (mode == DHT_PERIODIC) begin
                  s_d.cnt = load;
                end else begin
                  s_d.done = 1'b1;
                end
              end else begin
                s_d.cnt = s_q.cnt - 16'h0001;
              end
            end
          end
        end
        DHT_EDGE_CNT: begin
          if (edge_p) begin
            if (s_q.cnt == match) begin
              s_d.flag = 1'b1;
              s_d.cnt = load;
            end else begin
              s_d.cnt = s_q.cnt - 16'h0001;
            end
          end
        end
        DHT_EDGE_TIME: begin
          s_d.cnt = (s_q.cnt == 16'h0000) ? load : s_q.cnt - 16'h0001;
          if (edge_p) begin
            s_d.cap = s_q.cnt;
            s_d.flag = 1'b1;
          end
        end
        DHT_PWM: begin
          s_d.cnt = (s_q.cnt == 16'h0000) ? load : s_q.cnt - 16'h0001;
          s_d.pwm = (s_q.cnt > match) ^ inv;
        end
        default: begin
          s_d.cnt = s_q.cnt;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // capture value shown in edge time mode
  assign value = (mode == DHT_EDGE_TIME) ? s_q.cap : s_q.cnt;
  assign flag = s_q.flag;
  assign pwm = s_q.pwm;

  AST_ONESHOT_STOP: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.done && en && mode == DHT_ONESHOT) ##1 en |-> !s_q.flag && s_q.cnt == 16'h0000)
    else $error("one-shot half kept counting");
  AST_PERIODIC_RELOAD: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.flag && $past(en) && $past(mode) == DHT_PERIODIC) |-> s_q.cnt == $past(load))
    else $error("periodic half did not reload");
  AST_STALL_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    (en && pause) |=> $stable(s_q.cnt) && !s_q.flag)
    else $error("half counted while stalled");
  AST_CAPTURE: assert property (@(posedge mclk) disable iff (!nrst)
    (en && mode == DHT_EDGE_TIME && edge_p) |=> s_q.flag && s_q.cap == $past(s_q.cnt))
    else $error("edge time not captured");
  AST_PWM_LEVEL: assert property (@(posedge mclk) disable iff (!nrst)
    (en && mode == DHT_PWM) ##1 (en && mode == DHT_PWM && $stable(inv) && $stable(match))
    |-> pwm == (($past(s_q.cnt) > match) ^ inv))
    else $error("pwm level or polarity wrong");
  AST_PRESCALE: assert property (@(posedge mclk) disable iff (!nrst)
    (en && tmode && !pause && s_q.pcnt != 8'h00) |=> $stable(s_q.cnt) && !s_q.flag)
    else $error("counter moved between prescale ticks");

endmodule

// ---- verilog/dht_top.sv ----
// three dual half timer blocks behind an ahb-lite register slave
// assumes one master, word transfers, pins synchronous to mclk
//
// Functional notes
// - Three identical blocks each hold two 16-bit halves that run alone as timer or event counter.
// - A block can join its halves into one 32-bit timer or one 32-bit real-time counter.
// - The joined timer offers one-shot, periodic and real-time counting.
// - A 16-bit half offers one-shot and periodic counting behind an 8-bit prescaler.
// - A 16-bit half can instead capture events on its pin or drive a pwm output.
// - The blocks count or time edges applied to the timer input pins.
// - Pwm mode drives a simple waveform on the pin whose polarity software can invert.
// - Real-time mode counts an outside 32.768 kHz clock input that the outside must supply.
// - When enabled, one-shot and periodic counting stalls while the processor halt flag is set.
// - Capture either counts input edges or records the time of an input edge.
`timescale 1ns/1ps
`include "dht_defs.svh"

module dht_top
  import dht_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic cpu_halt,
  input wire logic rtc_clk_in,
  input wire logic [2*`DHT_NBLK-1:0] ccp_in,
  output logic [2*`DHT_NBLK-1:0] ccp_out,
  output logic [2*`DHT_NBLK-1:0] ccp_oe
);

  localparam int NH = 2 * `DHT_NBLK;

  dht_top_t s_q;
  dht_top_t s_d;
  logic [NH:0] rise;
  logic [NH-1:0][15:0] hv;
  logic [NH-1:0] hf;
  logic [NH-1:0] hp;
  logic acc;

  // ------------------------------------------------------------
  // address decode helper
  // ------------------------------------------------------------

  // word lies inside an existing block
  function automatic logic dht_blk_ok(input logic [7:0] a);
    dht_blk_ok = (a[7:5] < 3'(`DHT_NBLK));
  endfunction

  // ------------------------------------------------------------
  // pin edges and the timer halves
  // ------------------------------------------------------------

  // pin edges, rtc input on top bit
  dht_edge #(
    .W(NH + 1)
  ) u_edge (
    .mclk(mclk),
    .nrst(nrst),
    .din({rtc_clk_in, ccp_in}),
    .rise(rise)
  );

  for (genvar i = 0; i < NH; i++) begin : g_half
    localparam int B = i / 2;
    localparam int H = i % 2;
    localparam int MB = (H == 0) ? `DHT_CFG_MODE_A_LSB : `DHT_CFG_MODE_B_LSB;
    logic [23:0] ld;
    logic [15:0] mt;
    assign ld = (H == 0) ? s_q.load_a[B] : s_q.load_b[B];
    assign mt = (H == 0) ? s_q.match_a[B] : s_q.match_b[B];
    dht_half u_half (
      .mclk(mclk),
      .nrst(nrst),
      .en(s_q.cfg[B][`DHT_CFG_EN_A + H] && s_q.cfg[B][`DHT_CFG_JOIN] == DHT_SPLIT),
      .mode(dht_mode_t'(s_q.cfg[B][MB +: 3])),
      .stall(s_q.cfg[B][`DHT_CFG_STALL_A + H]),
      .halt(cpu_halt),
      .inv(s_q.cfg[B][`DHT_CFG_INV_A + H]),
      .edge_p(rise[i]),
      .load(ld[`DHT_LOAD_VAL]),
      .presc(ld[`DHT_LOAD_PRESC]),
      .match(mt),
      .value(hv[i]),
      .flag(hf[i]),
      .pwm(hp[i])
    );
  end

  // ------------------------------------------------------------
  // bus, registers and joined counters
  // ------------------------------------------------------------

  // transfer taken in its address phase
  assign acc = hsel && htrans[1] && hready;

  always_comb begin
    logic [NH-1:0][2:0] clr;
    logic [2:0] set;
    logic [31:0] ld32;
    logic [31:0] mt32;
    logic [31:0] inc;
    logic j32;
    logic spl;
    dht_join_t jm;
    dht_mode_t m;
    clr = '0;
    set = '0;
    ld32 = '0;
    mt32 = '0;
    inc = '0;
    j32 = 1'b0;
    spl = 1'b0;
    jm = DHT_SPLIT;
    m = DHT_ONESHOT;
    s_d = s_q;

    // address phase: writes need no wait, reads take one
    s_d.wpend = acc && hwrite;
    s_d.waddr = haddr[7:0];
    if (acc && !hwrite) begin
      s_d.rd_pend = 1'b1;
      s_d.raddr = haddr[7:0];
      s_d.hready = 1'b0;
    end

    // read data from settled registers; unmapped reads zero
    if (s_q.rd_pend) begin
      s_d.rd_pend = 1'b0;
      s_d.hready = 1'b1;
      s_d.rdata = 32'h0000_0000;
      for (int b = 0; b < `DHT_NBLK; b++) begin
        j32 = s_q.cfg[b][`DHT_CFG_JOIN] != DHT_SPLIT;
        if (dht_blk_ok(s_q.raddr) && s_q.raddr[7:5] == 3'(b)) begin
          if (s_q.raddr[4:0] == `DHT_OFF_CFG) begin
            s_d.rdata = {16'h0000, s_q.cfg[b]};
          end else if (s_q.raddr[4:0] == `DHT_OFF_LOAD_A) begin
            s_d.rdata = {8'h00, s_q.load_a[b]};
          end else if (s_q.raddr[4:0] == `DHT_OFF_LOAD_B) begin
            s_d.rdata = {8'h00, s_q.load_b[b]};
          end else if (s_q.raddr[4:0] == `DHT_OFF_MATCH_A) begin
            s_d.rdata = {16'h0000, s_q.match_a[b]};
          end else if (s_q.raddr[4:0] == `DHT_OFF_MATCH_B) begin
            s_d.rdata = {16'h0000, s_q.match_b[b]};
          end else if (s_q.raddr[4:0] == `DHT_OFF_VAL_A) begin
            s_d.rdata = {16'h0000, j32 ? s_q.cnt32[b][15:0] : hv[2*b]};
          end else if (s_q.raddr[4:0] == `DHT_OFF_VAL_B) begin
            s_d.rdata = {16'h0000, j32 ? s_q.cnt32[b][31:16] : hv[2*b+1]};
          end else if (s_q.raddr[4:0] == `DHT_OFF_STAT) begin
            s_d.rdata = {29'h0000_0000, s_q.stat[b]};
          end
        end
      end
    end

    // data phase of a write; unmapped writes are dropped
    if (s_q.wpend && dht_blk_ok(s_q.waddr)) begin
      for (int b = 0; b < `DHT_NBLK; b++) begin
        if (s_q.waddr[7:5] == 3'(b)) begin
          if (s_q.waddr[4:0] == `DHT_OFF_CFG) begin
            s_d.cfg[b] = hwdata[15:0];
          end else if (s_q.waddr[4:0] == `DHT_OFF_LOAD_A) begin
            s_d.load_a[b] = hwdata[23:0];
          end else if (s_q.waddr[4:0] == `DHT_OFF_LOAD_B) begin
            s_d.load_b[b] = hwdata[23:0];
          end else if (s_q.waddr[4:0] == `DHT_OFF_MATCH_A) begin
            s_d.match_a[b] = hwdata[15:0];
          end else if (s_q.waddr[4:0] == `DHT_OFF_MATCH_B) begin
            s_d.match_b[b] = hwdata[15:0];
          end else if (s_q.waddr[4:0] == `DHT_OFF_STAT) begin
            clr[b] = hwdata[2:0];
          end
        end
      end
    end

    // joined counter per block
    for (int b = 0; b < `DHT_NBLK; b++) begin
      jm = dht_join_t'(s_q.cfg[b][`DHT_CFG_JOIN]);
      m = dht_mode_t'(s_q.cfg[b][`DHT_CFG_MODE_A_LSB +: 3]);
      ld32 = {s_q.load_b[b][`DHT_LOAD_VAL], s_q.load_a[b][`DHT_LOAD_VAL]};
      mt32 = {s_q.match_b[b], s_q.match_a[b]};
      inc = s_q.cnt32[b] + 32'h0000_0001;
      set = '0;
      if (jm == DHT_SPLIT || !s_q.cfg[b][`DHT_CFG_EN_A]) begin
        s_d.cnt32[b] = ld32;
        s_d.done32[b] = 1'b0;
      end else if (jm == DHT_RTC) begin
        if (rise[NH]) begin
          s_d.cnt32[b] = inc;
          set[`DHT_STAT_J32] = (inc == mt32);
        end
      end else if (jm == DHT_JOINED && !(s_q.cfg[b][`DHT_CFG_STALL_A] && cpu_halt) &&
                   !s_q.done32[b] && (m == DHT_ONESHOT || m == DHT_PERIODIC)) begin
        if (s_q.cnt32[b] == 32'h0000_0000) begin
          set[`DHT_STAT_J32] = 1'b1;
          if (m == DHT_PERIODIC) begin
            s_d.cnt32[b] = ld32;
          end else begin
            s_d.done32[b] = 1'b1;
          end
        end else begin
          s_d.cnt32[b] = s_q.cnt32[b] - 32'h0000_0001;
        end
      end
      set[1:0] = {hf[2*b+1], hf[2*b]};
      s_d.stat[b] = (s_q.stat[b] & ~clr[b]) | set;
    end

    // pins driven in pwm mode only
    for (int i = 0; i < NH; i++) begin
      spl = s_q.cfg[i/2][`DHT_CFG_JOIN] == DHT_SPLIT;
      m = dht_mode_t'(s_q.cfg[i/2][((i % 2) * 3 + `DHT_CFG_MODE_A_LSB) +: 3]);
      s_d.ccp_out[i] = hp[i];
      s_d.ccp_oe[i] = spl && s_q.cfg[i/2][`DHT_CFG_EN_A + (i % 2)] && m == DHT_PWM;
    end
  end

  // state register; bus ready out of reset
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.hready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops, except hresp, which is tied low
  assign hreadyout = s_q.hready;
  assign hrdata = s_q.rdata;
  assign hresp = 1'b0;
  assign ccp_out = s_q.ccp_out;
  assign ccp_oe = s_q.ccp_oe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------

  AST_READ_WAIT: assert property (@(posedge mclk) disable iff (!nrst)
    (acc && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait");
  AST_STAT_SET: assert property (@(posedge mclk) disable iff (!nrst)
    hf[0] |=> s_q.stat[0][0])
    else $error("half flag lost in status");
  // joined checks watch the last block, where joined and real-time use get exercised
  AST_RTC_INC: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.cfg[2][`DHT_CFG_JOIN] == DHT_RTC && s_q.cfg[2][`DHT_CFG_EN_A] && rise[NH] && !s_d.wpend &&
     !s_q.wpend) |=> s_q.cnt32[2] == $past(s_q.cnt32[2]) + 32'h0000_0001)
    else $error("rtc did not step on slow clock edge");
  AST_J32_EXPIRE: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.cfg[2][`DHT_CFG_JOIN] == DHT_JOINED && s_q.cfg[2][`DHT_CFG_EN_A] && !cpu_halt && !s_q.done32[2] &&
     (s_q.cfg[2][`DHT_CFG_MODE_A_LSB +: 3] == DHT_ONESHOT ||
      s_q.cfg[2][`DHT_CFG_MODE_A_LSB +: 3] == DHT_PERIODIC) &&
     s_q.cnt32[2] == 32'h0000_0000 && !s_q.wpend)
    |=> s_q.stat[2][`DHT_STAT_J32] &&
    s_q.cnt32[2] == (($past(s_q.cfg[2][`DHT_CFG_MODE_A_LSB +: 3]) == DHT_PERIODIC) ?
    {$past(s_q.load_b[2][15:0]), $past(s_q.load_a[2][15:0])} : 32'h0000_0000))
    else $error("joined timer did not reload or stop and flag");
  AST_JOIN_PINS_OFF: assert property (@(posedge mclk) disable iff (!nrst)
    (s_q.cfg[2][`DHT_CFG_JOIN] != DHT_SPLIT) ##1 (s_q.cfg[2][`DHT_CFG_JOIN] != DHT_SPLIT)
    |-> ##1 ccp_oe[5:4] == 2'b00)
    else $error("pin driven while halves joined");

endmodule

// ---- verification/dht_pin_model.sv ----
// pin-side partner: edge sources on the capture pins and the slow real-time clock
// assumes its tasks are called right after a rising mclk edge
`timescale 1ns/1ps

module dht_pin_model (
  input wire logic mclk,
  input wire logic [5:0] ccp_out,
  input wire logic [5:0] ccp_oe,
  output logic [5:0] ccp_in,
  output logic rtc_clk_in
);
  // mclk cycles in half a period of the 32.768 khz input
  localparam int RTC_HALF = 1907;
  logic [5:0] src_q;

  initial begin
    src_q = 6'h00;
    rtc_clk_in = 1'b0;
  end

  // wire level: the timer wins where it drives, else our source
  assign ccp_in = (ccp_oe & ccp_out) | (~ccp_oe & src_q);

  task automatic pulse(input int idx);
    src_q[idx] <= 1'b1;
    repeat (3) @(posedge mclk);
    src_q[idx] <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // outside clock supply; only runs while a test needs it
  task automatic rtc_run(input int n);
    repeat (n) begin
      rtc_clk_in <= 1'b1;
      repeat (RTC_HALF) @(posedge mclk);
      rtc_clk_in <= 1'b0;
      repeat (RTC_HALF) @(posedge mclk);
    end
  endtask
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the three dual half timer blocks
// assumes the pin model on the capture pins and a single ahb-lite master here
`timescale 1ns/1ps
`include "dht_defs.svh"

module tb_top
  import dht_pkg::*;
;
  logic mclk;
  logic nrst;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic cpu_halt;
  logic rtc_clk_in;
  logic [2*`DHT_NBLK-1:0] ccp_in;
  logic [2*`DHT_NBLK-1:0] ccp_out;
  logic [2*`DHT_NBLK-1:0] ccp_oe;
  int mismatches;
  int num_checks;
  int hi;
  logic [31:0] rv;
  // rows: write address, write data, read address, expected read
  logic [31:0] rows [6][4];

  dht_top dut (
    .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cpu_halt(cpu_halt),
    .rtc_clk_in(rtc_clk_in), .ccp_in(ccp_in), .ccp_out(ccp_out), .ccp_oe(ccp_oe)
  );

  dht_pin_model pin (
    .mclk(mclk), .ccp_out(ccp_out), .ccp_oe(ccp_oe), .ccp_in(ccp_in), .rtc_clk_in(rtc_clk_in)
  );

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one single transfer; waits on hready, assumes no wait-state count
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    rv = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rv);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // high cycles of one pwm pin over two periods of ten
  task automatic hicount(input int b);
    hi = 0;
    repeat (20) begin
      @(posedge mclk);
      if (ccp_out[b] === 1'b1) hi++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------
  // clock, watchdog, tests
  // ------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // whole run is about 13k cycles, so three times that means a hang
  initial begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    stop_test();
  end

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    cpu_halt = 1'b0;
    mismatches = 0;
    num_checks = 0;
    rows = '{'{32'h0000_0004, 32'hFFAB_1234, 32'h0000_0004, 32'h00AB_1234},
             '{32'h0000_002C, 32'hFFFF_5A5A, 32'h0000_002C, 32'h0000_5A5A},
             '{32'h0000_0048, 32'h0000_0042, 32'h0000_0058, 32'h0000_0042},
             '{32'h0000_0014, 32'h0000_7777, 32'h0000_0014, 32'h0000_1234},
             '{32'h0000_0064, 32'h1234_5678, 32'h0000_0064, 32'h0000_0000},
             '{32'h0000_0030, 32'h0001_FFFF, 32'h0000_0030, 32'h0000_FFFF}};
    cyc(10);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][0], rows[i][1]);
      rd("row read", rows[i][2], rows[i][3]);
    end
    $display("test rows done");
    // mid-run reset clears every block; block 3 is unmapped
    nrst <= 1'b0;
    cyc(2);
    chk("oe in reset", 32'h0000_0000, {26'h0, ccp_oe});
    chk("hresp okay", 32'h0000_0000, {31'h0, hresp});
    nrst <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      rd("reset value", 32'(i * 4), 32'h0000_0000);
    end
    $display("test reset done");
    wr(32'h0000_0004, 32'h00FF_0002);
    wr(32'h0000_0000, 32'h0000_0100);
    cyc(50);
    rd("prescaled val", 32'h0000_0014, 32'h0000_0002);
    rd("stat early", 32'h0000_001C, 32'h0000_0000);
    cyc(900);
    rd("oneshot val", 32'h0000_0014, 32'h0000_0000);
    rd("oneshot stat", 32'h0000_001C, 32'h0000_0001);
    wr(32'h0000_001C, 32'h0000_0001);
    rd("stat cleared", 32'h0000_001C, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0000_0000);
    wr(32'h0000_0004, 32'h0000_0003);
    wr(32'h0000_0000, 32'h0000_0104);
    cyc(20);
    wr(32'h0000_001C, 32'h0000_0001);
    cyc(20);
    rd("periodic stat", 32'h0000_001C, 32'h0000_0001);
    wr(32'h0000_0000, 32'h0000_0000);
    $display("test oneshot periodic done");
    wr(32'h0000_0024, 32'h0000_00FF);
    cpu_halt <= 1'b1;
    wr(32'h0000_0020, 32'h0000_0500);
    cyc(20);
    rd("stalled val", 32'h0000_0034, 32'h0000_00FF);
    cpu_halt <= 1'b0;
    cyc(300);
    rd("resumed val", 32'h0000_0034, 32'h0000_0000);
    rd("resumed stat", 32'h0000_003C, 32'h0000_0001);
    $display("test stall done");
    wr(32'h0000_0044, 32'h0000_0040);
    wr(32'h0000_0040, 32'h0000_0101);
    cyc(100);
    rd("joined stat", 32'h0000_005C, 32'h0000_0004);
    rd("joined low", 32'h0000_0054, 32'h0000_0000);
    rd("joined high", 32'h0000_0058, 32'h0000_0000);
    wr(32'h0000_005C, 32'h0000_0007);
    wr(32'h0000_0040, 32'h0000_0000);
    wr(32'h0000_004C, 32'h0000_0043);
    wr(32'h0000_0040, 32'h0000_0102);
    pin.rtc_run(3);
    cyc(4);
    rd("rtc val", 32'h0000_0054, 32'h0000_0043);
    rd("rtc stat", 32'h0000_005C, 32'h0000_0004);
    wr(32'h0000_0040, 32'h0000_0000);
    $display("test joined rtc done");
    wr(32'h0000_001C, 32'h0000_0007);
    wr(32'h0000_0008, 32'h0000_0005);
    wr(32'h0000_0010, 32'h0000_0002);
    wr(32'h0000_0000, 32'h0000_0240);
    pin.pulse(1);
    pin.pulse(1);
    rd("edge count", 32'h0000_0018, 32'h0000_0003);
    rd("count stat", 32'h0000_001C, 32'h0000_0000);
    pin.pulse(1);
    pin.pulse(1);
    rd("count match", 32'h0000_001C, 32'h0000_0002);
    wr(32'h0000_0000, 32'h0000_0000);
    wr(32'h0000_003C, 32'h0000_0007);
    wr(32'h0000_0028, 32'h0000_FFFF);
    wr(32'h0000_0020, 32'h0000_0260);
    cyc(10);
    rd("time idle", 32'h0000_003C, 32'h0000_0000);
    pin.pulse(3);
    rd("time stat", 32'h0000_003C, 32'h0000_0002);
    // remaining pins: one edge each, the halves on pins 0, 2, 4 and 5 in edge time mode
    wr(32'h0000_001C, 32'h0000_0007);
    wr(32'h0000_003C, 32'h0000_0007);
    wr(32'h0000_005C, 32'h0000_0007);
    wr(32'h0000_0000, 32'h0000_010C);
    wr(32'h0000_0020, 32'h0000_010C);
    wr(32'h0000_0040, 32'h0000_036C);
    for (int p = 0; p < 6; p += 2) pin.pulse(p);
    pin.pulse(5);
    rd("pin0 stat", 32'h0000_001C, 32'h0000_0001);
    rd("pin2 stat", 32'h0000_003C, 32'h0000_0001);
    rd("pin4 pin5 stat", 32'h0000_005C, 32'h0000_0003);
    wr(32'h0000_0000, 32'h0000_0000);
    $display("test capture done");
    wr(32'h0000_0004, 32'h0000_0009);
    wr(32'h0000_000C, 32'h0000_0006);
    wr(32'h0000_0000, 32'h0000_0110);
    cyc(5);
    hicount(0);
    chk("pwm highs", 32'h0000_0006, 32'(hi));
    chk("pwm oe", 32'h0000_0001, {31'h0, ccp_oe[0]});
    wr(32'h0000_0000, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0000_1110);
    cyc(5);
    hicount(0);
    chk("inverted highs", 32'h0000_000E, 32'(hi));
    wr(32'h0000_0000, 32'h0000_0000);
    cyc(3);
    chk("pwm oe off", 32'h0000_0000, {31'h0, ccp_oe[0]});
    $display("test pwm done");
    stop_test();
  end
endmodule
